//--- cnlp_pkg.sv
// cnlp_pkg: constants, states and carrier structs for the can low-power control block
// assumes one 100 MHz clock and a plain strobe register port
package cnlp_pkg;

  // register offsets
  localparam logic [3:0] CNLP_MCR_OFS   = 4'h0;  // module_config_reg
  localparam logic [3:0] CNLP_ESR_OFS   = 4'h4;  // error and status register
  localparam logic [3:0] CNLP_IMASK_OFS = 4'h8;  // message buffer interrupt mask
  localparam logic [3:0] CNLP_IFLAG_OFS = 4'hc;  // message buffer interrupt flags

  // module_config_reg field positions
  localparam int CNLP_MCR_STOP_BIT   = 15;
  localparam int CNLP_MCR_FRZ_BIT    = 14;
  localparam int CNLP_MCR_HALT_BIT   = 12;
  localparam int CNLP_MCR_NRDY_BIT   = 11;
  localparam int CNLP_MCR_WMASK_BIT  = 10;
  localparam int CNLP_MCR_SRST_BIT   = 9;
  localparam int CNLP_MCR_HALTST_BIT = 8;
  localparam int CNLP_MCR_SACK_BIT   = 7;
  localparam int CNLP_MCR_SWAKE_BIT  = 6;
  localparam int CNLP_MCR_APS_BIT    = 5;

  // error and status register field positions
  localparam int CNLP_ESR_BOFF_BIT = 5;
  localparam int CNLP_ESR_ERR_BIT  = 1;
  localparam int CNLP_ESR_WAKE_BIT = 0;

  // reset values
  localparam logic [15:0] CNLP_MCR_RST = 16'h0000;

  // resync: consecutive recessive bits that mark bus idle
  localparam int CNLP_IDLE_BITS = 11;
  // third intermission bit position
  localparam int CNLP_INTER_BITS = 3;

  // controller low-power state
  typedef enum logic [2:0] {
    CNLP_RUN,
    CNLP_RESYNC,
    CNLP_WAIT_BUS,
    CNLP_DRAIN,
    CNLP_STOPPED,
    CNLP_WAKE_SYNC
  } cnlp_state_t;

  // core activity, all qualified by the protocol engine
  typedef struct packed {
    logic rx_busy;     // frame being received
    logic tx_busy;     // frame being sent
    logic move_busy;   // staging_buffer <-> message_buffer move
    logic tx_pending;  // any message_buffer armed for transmit
    logic bus_off;     // bus_off_state
    logic bit_tick;    // one pulse per bit time
  } cnlp_core_t;

  // register port request
  typedef struct packed {
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } cnlp_req_t;

endpackage : cnlp_pkg

//--- cnlp_edge_det.sv
// cnlp_edge_det: recessive-to-dominant edge detector on the bus receive line
// assumes rx is already synchronous to ref_clk_in; recessive is 1
module cnlp_edge_det
  import cnlp_pkg::*;
(
  // clock and reset
  input  wire logic ref_clk_in,
  input  wire logic srst_in,
  // bus line
  input  wire logic rx_in,
  // detected edge, one-cycle pulse
  output logic      fall_out
);
  logic prev_q;
  logic prev_d;

  // previous level, reset to recessive so no false edge
  always_comb begin
    prev_d = rx_in;
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      prev_q <= 1'b1;
    end else begin
      prev_q <= prev_d;
    end
  end

  assign fall_out = prev_q & ~rx_in;

endmodule : cnlp_edge_det

//--- cnlp_bit_cnt.sv
// cnlp_bit_cnt: counts consecutive recessive bit samples on bit ticks
// assumes bit_tick marks the sample point of each bit
module cnlp_bit_cnt
  import cnlp_pkg::*;
#(
  parameter int WIDTH = 4
) (
  // clock and reset
  input  wire logic             ref_clk_in,
  input  wire logic             srst_in,
  // control
  input  wire logic             clr_in,
  input  wire logic             hold_in,
  input  wire logic             bit_tick_in,
  input  wire logic             rx_in,
  // count of recessive bits, saturating
  output logic [WIDTH-1:0]      cnt_out
);
  logic [WIDTH-1:0] cnt_q;
  logic [WIDTH-1:0] cnt_d;

  initial begin
    if (WIDTH < 4) $error("cnlp_bit_cnt: WIDTH too small for idle count");
  end

  // dominant restarts, hold freezes, saturate at all ones
  always_comb begin
    cnt_d = cnt_q;
    if (clr_in) begin
      cnt_d = '0;
    end else if (!hold_in && bit_tick_in) begin
      if (!rx_in) begin
        cnt_d = '0;
      end else if (cnt_q != {WIDTH{1'b1}}) begin
        cnt_d = cnt_q + WIDTH'(1);
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign cnt_out = cnt_q;

endmodule : cnlp_bit_cnt

//--- cnlp_ctrl.sv
// cnlp_ctrl: stop mode, self-wake and auto power save control of a can controller
// assumes the protocol engine reports activity and bit ticks on cnlp_core_t
// Behaviour
// - stop proceeds only on idle or third intermission
// - drain internal activity, then gate clocks
// - register port keeps working while stopped
// - stopped: ignore rx, drive tx recessive
// - stop entry: lose sync, set ack, not-ready
// - stopped bus edge sets wakeup flag
// - wakeup interrupt only when mask set
// - hard or soft reset leaves stop
// - clearing request bit leaves stop
// - self-wake edge clears request, restarts clocks
// - after self-wake receive frame, no arbitration
// - bus-off recovery count pauses during stop
// - early edge may skip acknowledge entirely
// - halt: leave, resync eleven recessive bits first
// - one-quantum offset lasts until next edge
// - auto power save gates clocks while idle
// - idle: no frame, move, pending, access, halt
// - thirty-five interrupt sources, any may wake
//
// The plain strobed port and the register addresses were left to the implementer.
module cnlp_ctrl
  import cnlp_pkg::*;
#(
  parameter int MB_NUM = 32
) (
  // clock and reset
  input  wire logic              ref_clk_in,
  input  wire logic              srst_in,
  // register port
  input  wire logic [3:0]        reg_addr_in,
  input  wire logic [31:0]       reg_wdata_in,
  input  wire logic              reg_wr_in,
  input  wire logic              reg_rd_in,
  output logic [31:0]            reg_rdata_out,
  // protocol engine status
  input  wire cnlp_core_t        core_in,
  input  wire logic              err_event_in,
  input  wire logic [MB_NUM-1:0] mb_event_in,
  // can pins
  input  wire logic              can_rx_in,
  input  wire logic              core_tx_in,
  output logic                   can_tx_out,
  // to the protocol engine
  output logic                   core_rx_out,
  output logic                   clk_gate_en_out,
  output logic                   core_soft_rst_out,
  output logic                   bus_off_state_hold_out,
  output logic                   listen_sof_out,
  // interrupt request
  output logic                   irq_out
);
  initial begin
    if (MB_NUM < 1 || MB_NUM > 32) $error("cnlp_ctrl: MB_NUM must be 1..32");
  end

  cnlp_state_t       st_q, st_d;
  logic [15:0]       mcr_q, mcr_d;
  logic              wake_q, wake_d;
  logic              err_q, err_d;
  logic              swake_lat_q, swake_lat_d;
  logic              sof_q, sof_d;
  logic [MB_NUM-1:0] imask_q, imask_d;
  logic [MB_NUM-1:0] iflag_q, iflag_d;
  logic [31:0]       rdata_q, rdata_d;
  logic              gate_q, gate_d;
  logic              fall;
  logic [3:0]        rcnt;
  logic              cnt_clr;
  logic              host_acc;
  logic              mcr_wr;
  logic              srst_any;
  logic              stopped;

  assign host_acc = reg_wr_in | reg_rd_in;
  assign mcr_wr   = reg_wr_in && (reg_addr_in == CNLP_MCR_OFS);
  // soft reset bit written as one resets like a hard reset, all but the read data register
  assign srst_any = srst_in | (mcr_wr & reg_wdata_in[CNLP_MCR_SRST_BIT]);
  assign stopped  = (st_q == CNLP_STOPPED);

  // bus edge detector sees the raw pin even while stopped
  cnlp_edge_det u_edge (
    .ref_clk_in (ref_clk_in),
    .srst_in    (srst_any),
    .rx_in      (can_rx_in),
    .fall_out   (fall)
  );

  // recessive run counter for idle, intermission and resync
  cnlp_bit_cnt #(.WIDTH(4)) u_cnt (
    .ref_clk_in  (ref_clk_in),
    .srst_in     (srst_any),
    .clr_in      (cnt_clr),
    .hold_in     (1'b0),
    .bit_tick_in (core_in.bit_tick),
    .rx_in       (can_rx_in),
    .cnt_out     (rcnt)
  );

  // low-power state machine and module_config_reg
  always_comb begin
    st_d        = st_q;
    mcr_d       = mcr_q;
    swake_lat_d = swake_lat_q;
    sof_d       = 1'b0;
    cnt_clr     = 1'b0;
    if (mcr_wr) begin
      // writable: stop, freeze, halt, wake mask, self-wake, auto power save
      mcr_d[CNLP_MCR_STOP_BIT]  = reg_wdata_in[CNLP_MCR_STOP_BIT];
      mcr_d[CNLP_MCR_FRZ_BIT]   = reg_wdata_in[CNLP_MCR_FRZ_BIT];
      mcr_d[CNLP_MCR_HALT_BIT]  = reg_wdata_in[CNLP_MCR_HALT_BIT];
      mcr_d[CNLP_MCR_WMASK_BIT] = reg_wdata_in[CNLP_MCR_WMASK_BIT];
      mcr_d[CNLP_MCR_SWAKE_BIT] = reg_wdata_in[CNLP_MCR_SWAKE_BIT];
      mcr_d[CNLP_MCR_APS_BIT]   = reg_wdata_in[CNLP_MCR_APS_BIT];
    end
    // halt state follows freeze and halt request in every state, stop included
    mcr_d[CNLP_MCR_HALTST_BIT] = mcr_d[CNLP_MCR_FRZ_BIT] & mcr_d[CNLP_MCR_HALT_BIT];
    unique case (st_q)
      CNLP_RUN: begin
        if (mcr_q[CNLP_MCR_STOP_BIT]) begin
          if (mcr_q[CNLP_MCR_HALTST_BIT]) begin
            // halt is dropped and the bus must be seen idle again
            mcr_d[CNLP_MCR_HALT_BIT]   = 1'b0;
            mcr_d[CNLP_MCR_HALTST_BIT] = 1'b0;
            cnt_clr = 1'b1;
            st_d    = CNLP_RESYNC;
          end else begin
            st_d = CNLP_WAIT_BUS;
          end
        end
      end
      CNLP_RESYNC: begin
        if (rcnt >= 4'(CNLP_IDLE_BITS)) begin
          st_d = CNLP_WAIT_BUS;
        end
      end
      CNLP_WAIT_BUS: begin
        // idle bus, or third intermission bit recessive after a frame
        if (!core_in.rx_busy && !core_in.tx_busy
            && rcnt >= 4'(CNLP_INTER_BITS)) begin
          st_d = CNLP_DRAIN;
        end
      end
      CNLP_DRAIN: begin
        if (!core_in.move_busy && !core_in.rx_busy && !core_in.tx_busy) begin
          st_d = CNLP_STOPPED;
          mcr_d[CNLP_MCR_SACK_BIT] = 1'b1;
          mcr_d[CNLP_MCR_NRDY_BIT] = 1'b1;
          swake_lat_d = mcr_q[CNLP_MCR_SWAKE_BIT];
        end
      end
      CNLP_STOPPED: begin
        if (fall && swake_lat_q) begin
          // self-wake: clear request, take the edge as start of frame
          mcr_d[CNLP_MCR_STOP_BIT] = 1'b0;
          sof_d = 1'b1;
        end
        if (!mcr_d[CNLP_MCR_STOP_BIT]) begin
          mcr_d[CNLP_MCR_SACK_BIT] = 1'b0;
          cnt_clr = ~sof_d;
          st_d    = CNLP_WAKE_SYNC;
        end
      end
      CNLP_WAKE_SYNC: begin
        // ready once resynchronised: idle bus or frame start seen
        if (rcnt >= 4'(CNLP_IDLE_BITS) || sof_q || core_in.rx_busy) begin
          mcr_d[CNLP_MCR_NRDY_BIT] = 1'b0;
          st_d = CNLP_RUN;
        end
      end
      default: st_d = CNLP_RUN;
    endcase
    // an edge right after request with self-wake abandons entry, no ack
    if ((st_q == CNLP_WAIT_BUS || st_q == CNLP_DRAIN) && fall
        && mcr_q[CNLP_MCR_SWAKE_BIT]) begin
      mcr_d[CNLP_MCR_STOP_BIT] = 1'b0;
      sof_d = 1'b1;
      st_d  = CNLP_RUN;
    end
    // clearing the request before entry completes just abandons it
    if ((st_q == CNLP_WAIT_BUS || st_q == CNLP_DRAIN || st_q == CNLP_RESYNC)
        && !mcr_d[CNLP_MCR_STOP_BIT]) begin
      st_d = CNLP_RUN;
      // an entry cut short on the drain edge must not leave ack or not-ready stuck
      mcr_d[CNLP_MCR_SACK_BIT] = 1'b0;
      mcr_d[CNLP_MCR_NRDY_BIT] = 1'b0;
    end
  end

  // status flags: hardware set wins over software clear
  always_comb begin
    wake_d  = wake_q;
    err_d   = err_q;
    iflag_d = iflag_q;
    imask_d = imask_q;
    if (reg_wr_in && reg_addr_in == CNLP_ESR_OFS) begin
      // write one to clear
      if (reg_wdata_in[CNLP_ESR_WAKE_BIT]) wake_d = 1'b0;
      if (reg_wdata_in[CNLP_ESR_ERR_BIT])  err_d  = 1'b0;
    end
    if (reg_wr_in && reg_addr_in == CNLP_IFLAG_OFS) begin
      iflag_d = iflag_q & ~reg_wdata_in[MB_NUM-1:0];
    end
    if (reg_wr_in && reg_addr_in == CNLP_IMASK_OFS) begin
      imask_d = reg_wdata_in[MB_NUM-1:0];
    end
    if (stopped && fall) wake_d = 1'b1;
    if (err_event_in)    err_d  = 1'b1;
    iflag_d = iflag_d | mb_event_in;
  end

  // auto power save: gate while every idle condition holds
  always_comb begin
    gate_d = 1'b0;
    if (mcr_q[CNLP_MCR_APS_BIT] && st_q == CNLP_RUN
        && !core_in.rx_busy && !core_in.tx_busy
        && !core_in.move_busy && !core_in.tx_pending
        && !host_acc
        && !mcr_q[CNLP_MCR_HALTST_BIT] && !mcr_q[CNLP_MCR_STOP_BIT]
        && !core_in.bus_off) begin
      gate_d = 1'b1;
    end
  end

  // read data, one cycle after the strobe; port stays alive when stopped
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        CNLP_MCR_OFS:   rdata_d = {16'h0000, mcr_q};
        CNLP_ESR_OFS: begin
          rdata_d[CNLP_ESR_BOFF_BIT] = core_in.bus_off;
          rdata_d[CNLP_ESR_ERR_BIT]  = err_q;
          rdata_d[CNLP_ESR_WAKE_BIT] = wake_q;
        end
        CNLP_IMASK_OFS: rdata_d[MB_NUM-1:0] = imask_q;
        CNLP_IFLAG_OFS: rdata_d[MB_NUM-1:0] = iflag_q;
        default:        rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_any) begin
      st_q        <= CNLP_RUN;
      mcr_q       <= CNLP_MCR_RST;
      wake_q      <= 1'b0;
      err_q       <= 1'b0;
      swake_lat_q <= 1'b0;
      sof_q       <= 1'b0;
      imask_q     <= '0;
      iflag_q     <= '0;
      gate_q      <= 1'b0;
    end else begin
      st_q        <= st_d;
      mcr_q       <= mcr_d;
      wake_q      <= wake_d;
      err_q       <= err_d;
      swake_lat_q <= swake_lat_d;
      sof_q       <= sof_d;
      imask_q     <= imask_d;
      iflag_q     <= iflag_d;
      gate_q      <= gate_d;
    end
  end

  // read data register resets only on hard reset so a soft reset read completes
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata_out     = rdata_q;
  // stopped: tx recessive, rx forced recessive so the engine sees nothing
  assign can_tx_out        = stopped ? 1'b1 : core_tx_in;
  assign core_rx_out       = stopped ? 1'b1 : can_rx_in;
  // clock gate covers the engine only, not this register logic
  assign clk_gate_en_out   = ~(stopped | gate_q);
  assign core_soft_rst_out = srst_any;
  // bus-off recovery count frozen during stop, resumes after
  assign bus_off_state_hold_out   = (st_q == CNLP_DRAIN) | stopped;
  // edge offset of a quantum is corrected by the next edge's resync
  assign listen_sof_out    = sof_q;
  // thirty-five sources: message buffers, bus-off, error, wake
  assign irq_out = (|(iflag_q & imask_q)) | err_q | core_in.bus_off
                   | (wake_q & mcr_q[CNLP_MCR_WMASK_BIT]);

  a_ack_on_stop: assert property (@(posedge ref_clk_in) disable iff (srst_any)
    $rose(stopped) |-> mcr_q[CNLP_MCR_SACK_BIT] && mcr_q[CNLP_MCR_NRDY_BIT])
    else $error("ack or not-ready missing on stop entry");
  a_tx_recessive: assert property (@(posedge ref_clk_in) disable iff (srst_any)
    stopped |-> can_tx_out && !clk_gate_en_out)
    else $error("tx not recessive or clocks running while stopped");
  a_rx_ignored: assert property (@(posedge ref_clk_in) disable iff (srst_any)
    stopped |-> core_rx_out)
    else $error("receive line not masked while stopped");
  a_wake_flag_set: assert property (@(posedge ref_clk_in) disable iff (srst_any)
    stopped && fall |=> wake_q)
    else $error("wakeup flag not set by bus edge");
  a_wake_sticky: assert property (@(posedge ref_clk_in) disable iff (srst_any)
    wake_q && !(reg_wr_in && reg_addr_in == CNLP_ESR_OFS) |=> wake_q)
    else $error("wakeup flag lost without a clear");
  a_wake_irq_mask: assert property (@(posedge ref_clk_in) disable iff (srst_any)
    wake_q && !mcr_q[CNLP_MCR_WMASK_BIT] && !err_q && !core_in.bus_off
    && !(|(iflag_q & imask_q)) |-> !irq_out)
    else $error("wake interrupt raised while masked");
  a_soft_rst_exit: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    mcr_wr && reg_wdata_in[CNLP_MCR_SRST_BIT] |=> st_q == CNLP_RUN && mcr_q == CNLP_MCR_RST)
    else $error("soft reset did not leave stop");
  a_self_wake_exit: assert property (@(posedge ref_clk_in) disable iff (srst_any)
    stopped && swake_lat_q && fall && !mcr_wr
    |=> !mcr_q[CNLP_MCR_STOP_BIT] && !mcr_q[CNLP_MCR_SACK_BIT] && sof_q)
    else $error("self-wake did not clear request");
  a_clear_exit: assert property (@(posedge ref_clk_in) disable iff (srst_any)
    stopped && mcr_wr && !reg_wdata_in[CNLP_MCR_STOP_BIT] |=> !stopped ##1 clk_gate_en_out)
    else $error("clearing request did not leave stop");
  a_abort_no_ack: assert property (@(posedge ref_clk_in) disable iff (srst_any)
    (st_q == CNLP_WAIT_BUS || st_q == CNLP_DRAIN) && !mcr_d[CNLP_MCR_STOP_BIT]
    |=> st_q == CNLP_RUN && !mcr_q[CNLP_MCR_SACK_BIT] && !mcr_q[CNLP_MCR_NRDY_BIT])
    else $error("abandoned entry left ack or not-ready set");
  a_ready_again: assert property (@(posedge ref_clk_in) disable iff (srst_any)
    st_q == CNLP_WAKE_SYNC && (sof_q || core_in.rx_busy) |=> !mcr_q[CNLP_MCR_NRDY_BIT])
    else $error("not-ready still set after resync");
  a_entry_quiet: assert property (@(posedge ref_clk_in) disable iff (srst_any)
    st_q == CNLP_DRAIN && st_d == CNLP_STOPPED |-> !core_in.move_busy && !core_in.tx_busy)
    else $error("stop entered with activity");
  a_resync_first: assert property (@(posedge ref_clk_in) disable iff (srst_any)
    st_q == CNLP_RESYNC && st_d == CNLP_WAIT_BUS |-> rcnt >= 4'd11)
    else $error("left resync before eleven recessive bits");
  a_aps_idle: assert property (@(posedge ref_clk_in) disable iff (srst_any)
    gate_q |-> !$past(core_in.tx_pending) && !$past(host_acc))
    else $error("auto power save gated while busy");
  a_gate_restart: assert property (@(posedge ref_clk_in) disable iff (srst_any)
    gate_q && (core_in.rx_busy || core_in.tx_busy || core_in.tx_pending || host_acc)
    |=> clk_gate_en_out)
    else $error("clocks not restarted on activity");

endmodule : cnlp_ctrl

//--- cnlp_bus_node.sv
// cnlp_bus_node: behavioural can bus with one other node on it
// assumes recessive is 1 and the bus is a wired-and of every driver
module cnlp_bus_node #(
  parameter int BIT_CYC = 8
) (
  // clock
  input  wire logic clk_in,
  // other node asks for dominant, our transmit line
  input  wire logic dom_in,
  input  wire logic tx_in,
  // bus level and bit sample tick
  output logic      rx_out,
  output logic      tick_out
);
  timeunit 1ns;
  timeprecision 100ps;
  int   cnt_q = 0;
  logic dom_q = 1'b0;
  // bit timing runs free; the other node only changes level on a bit edge
  always @(posedge clk_in) begin
    cnt_q <= (cnt_q == BIT_CYC - 1) ? 0 : cnt_q + 1;
    if (cnt_q == BIT_CYC - 1) begin
      dom_q <= dom_in;
    end
  end
  // sample point mid-bit
  assign tick_out = (cnt_q == BIT_CYC / 2);
  // wired-and: a released bus floats back to recessive
  assign rx_out = tx_in & ~dom_q;
endmodule : cnlp_bus_node

//--- test_cnlp_ctrl.sv
// test_cnlp_ctrl: self-checking bench for the can low-power control block
// assumes cnlp_pkg and cnlp_bus_node are compiled first
module test_cnlp_ctrl import cnlp_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic        ref_clk_in = 1'b0;
  logic        srst_in = 1'b1;
  logic [3:0]  reg_addr_in = 4'h0;
  logic [31:0] reg_wdata_in = 32'h0;
  logic        reg_wr_in = 1'b0;
  logic        reg_rd_in = 1'b0;
  logic [31:0] reg_rdata_out;
  logic [4:0]  act = 5'h0;
  logic        tick;
  cnlp_core_t  core_in;
  logic        err_event_in = 1'b0;
  logic [31:0] mb_event_in = 32'h0;
  logic        can_rx_in;
  logic        core_tx_in = 1'b1;
  logic        can_tx_out;
  logic        core_rx_out;
  logic        clk_gate_en_out;
  logic        core_soft_rst_out;
  int          soft_n = 0;
  logic        bus_off_state_hold_out;
  logic        listen_sof_out;
  logic        irq_out;
  logic        dom = 1'b0;
  logic        rd_seen = 1'b0;
  logic [63:0] exp_q[$];
  int          bad_count = 0;
  int          comparisons = 0;
  int          tick_n = 0;
  logic [31:0] seed = 32'h3a6e;

  // act holds rx, tx, move, pending and bus-off activity
  assign core_in = cnlp_core_t'({act, tick});

  initial begin
    forever #5 ref_clk_in = ~ref_clk_in;
  end

  cnlp_ctrl #(.MB_NUM(32)) cnlp_ctrl_i (
    .ref_clk_in(ref_clk_in), .srst_in(srst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .core_in(core_in), .err_event_in(err_event_in),
    .mb_event_in(mb_event_in), .can_rx_in(can_rx_in), .core_tx_in(core_tx_in),
    .can_tx_out(can_tx_out), .core_rx_out(core_rx_out),
    .clk_gate_en_out(clk_gate_en_out), .core_soft_rst_out(core_soft_rst_out),
    .bus_off_state_hold_out(bus_off_state_hold_out), .listen_sof_out(listen_sof_out), .irq_out(irq_out));

  cnlp_bus_node #(.BIT_CYC(8)) cnlp_bus_node_i (
    .clk_in(ref_clk_in), .dom_in(dom), .tx_in(can_tx_out), .rx_out(can_rx_in),
    .tick_out(tick));

  always @(posedge ref_clk_in) begin
    if (tick) tick_n <= tick_n + 1;
    if (core_soft_rst_out && !srst_in) soft_n <= soft_n + 1;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s seen %h want %h", $time, msg, seen, exp);
    end
  endtask : check

  task automatic end_sim();
    $display("counts: %0d compared, %0d mismatched", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  // one-cycle strobes, changed only just after a rising edge
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b0;
  endtask : wr

  // note the masked expectation as the strobe goes out
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge ref_clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    exp_q.push_back({m, e});
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b0;
    @(posedge ref_clk_in);
  endtask : rd

  // watcher: the answer stands only in the cycle after the strobe
  always @(posedge ref_clk_in) begin
    logic [63:0] n;
    if (rd_seen) begin
      n = (exp_q.size() != 0) ? exp_q.pop_front() : {32'hffff_ffff, ~reg_rdata_out};
      check(reg_rdata_out & n[63:32], n[31:0] & n[63:32], "read data");
    end
    rd_seen <= reg_rd_in;
  end

  function automatic logic pick(input int s);
    case (s)
      0: return clk_gate_en_out;
      1: return listen_sof_out;
      default: return can_rx_in;
    endcase
  endfunction : pick

  // bounded wait; running out counts a mismatch and ends the run
  task automatic wait_for(input int s, input logic v, input string msg);
    int n = 0;
    @(negedge ref_clk_in);
    while (pick(s) !== v && n < 400) begin
      @(negedge ref_clk_in);
      n++;
    end
    check(32'(pick(s)), 32'(v), msg);
    if (n >= 400) end_sim();
  endtask : wait_for

  initial begin
    logic [31:0] r;
    logic [31:0] e;
    int t0;
    repeat (5) @(posedge ref_clk_in);
    srst_in <= 1'b0;
    rd(CNLP_MCR_OFS, CNLP_MCR_RST, '1);
    rd(4'h2, 32'h0, '1);
    check(32'(irq_out), 32'h0, "irq idle");
    $display("reset test done");
    // stop with only the wake mask enabled
    wr(CNLP_MCR_OFS, 32'h8400);
    wait_for(0, 1'b0, "stop gates clocks");
    rd(CNLP_MCR_OFS, 32'h8c80, '1);
    @(posedge ref_clk_in);
    core_tx_in <= 1'b0;
    dom <= 1'b1;
    wait_for(2, 1'b0, "bus dominant");
    check(32'(can_tx_out), 32'h1, "tx recessive");
    check(32'(core_rx_out), 32'h1, "rx ignored");
    rd(CNLP_ESR_OFS, 32'h1, 32'h1);
    check(32'(irq_out), 32'h1, "wake irq");
    rd(CNLP_MCR_OFS, 32'h8c80, '1);
    wr(CNLP_MCR_OFS, 32'h8000);
    @(negedge ref_clk_in);
    check(32'(irq_out), 32'h0, "wake masked");
    @(posedge ref_clk_in);
    dom <= 1'b0;
    core_tx_in <= 1'b1;
    wr(CNLP_MCR_OFS, 32'h0);
    rd(CNLP_MCR_OFS, 32'h0800, '1);
    wait_for(0, 1'b1, "clocks back");
    repeat (120) @(posedge ref_clk_in);
    rd(CNLP_MCR_OFS, 32'h0, '1);
    wr(CNLP_ESR_OFS, 32'h1);
    rd(CNLP_ESR_OFS, 32'h0, 32'h1);
    $display("stop test done");
    // self-wake set together with the request
    wr(CNLP_MCR_OFS, 32'h8040);
    wait_for(0, 1'b0, "self-wake stop");
    rd(CNLP_MCR_OFS, 32'h88c0, '1);
    dom <= 1'b1;
    wait_for(1, 1'b1, "frame start");
    wait_for(0, 1'b1, "clocks resume");
    rd(CNLP_MCR_OFS, 32'h0040, 32'h80c0);
    rd(CNLP_ESR_OFS, 32'h1, 32'h1);
    dom <= 1'b0;
    wr(CNLP_MCR_OFS, 32'h0);
    wr(CNLP_ESR_OFS, 32'h1);
    $display("self-wake test done");
    wr(CNLP_MCR_OFS, 32'h8000);
    wait_for(0, 1'b0, "stop again");
    wr(CNLP_MCR_OFS, 32'h0200);
    rd(CNLP_MCR_OFS, 32'h0, '1);
    wait_for(0, 1'b1, "soft reset wakes");
    check(32'(soft_n), 32'h1, "soft reset pulse");
    $display("soft reset test done");
    wr(CNLP_MCR_OFS, 32'h5000);
    rd(CNLP_MCR_OFS, 32'h0100, 32'h0100);
    t0 = tick_n;
    wr(CNLP_MCR_OFS, 32'hd000);
    wait_for(0, 1'b0, "stop from halt");
    check(32'((tick_n - t0) >= 11), 32'h1, "halt resync bits");
    wr(CNLP_MCR_OFS, 32'h0);
    wait_for(0, 1'b1, "halt stop exit");
    $display("halt test done");
    // auto power save: each activity alone restarts the clocks
    wr(CNLP_MCR_OFS, 32'h0020);
    wait_for(0, 1'b0, "idle gating");
    for (int i = 0; i < 5; i++) begin
      @(posedge ref_clk_in);
      act <= 5'h1 << i;
      wait_for(0, 1'b1, "busy restarts clocks");
      @(posedge ref_clk_in);
      act <= 5'h0;
      wait_for(0, 1'b0, "idle again");
    end
    wr(CNLP_MCR_OFS, 32'h0);
    $display("power save test done");
    @(posedge ref_clk_in);
    act <= 5'h1;
    wr(CNLP_MCR_OFS, 32'h8000);
    wait_for(0, 1'b0, "stop in bus-off");
    check(32'(bus_off_state_hold_out), 32'h1, "recovery paused");
    check(32'(irq_out), 32'h1, "bus-off irq");
    wr(CNLP_MCR_OFS, 32'h0);
    repeat (2) @(negedge ref_clk_in);
    check(32'(bus_off_state_hold_out), 32'h0, "recovery resumes");
    @(posedge ref_clk_in);
    act <= 5'h10;
    $display("bus-off test done");
    // receive busy holds entry; a bus edge with self-wake then abandons it
    wr(CNLP_MCR_OFS, 32'h8040);
    dom <= 1'b1;
    wait_for(1, 1'b1, "entry abandoned");
    @(posedge ref_clk_in);
    dom <= 1'b0;
    act <= 5'h0;
    rd(CNLP_MCR_OFS, 32'h0040, 32'h88c0);
    wr(CNLP_MCR_OFS, 32'h0);
    $display("abort test done");
    // random message buffer sources and masks
    for (int k = 0; k < 4; k++) begin
      r = xs();
      e = xs();
      wr(CNLP_IMASK_OFS, r);
      @(posedge ref_clk_in);
      mb_event_in <= e;
      @(posedge ref_clk_in);
      mb_event_in <= 32'h0;
      rd(CNLP_IFLAG_OFS, e, '1);
      @(negedge ref_clk_in);
      check(32'(irq_out), 32'(|(e & r)), "buffer irq");
      wr(CNLP_IFLAG_OFS, e);
      rd(CNLP_IFLAG_OFS, 32'h0, '1);
    end
    wr(CNLP_IMASK_OFS, 32'h0);
    @(posedge ref_clk_in);
    err_event_in <= 1'b1;
    @(posedge ref_clk_in);
    err_event_in <= 1'b0;
    rd(CNLP_ESR_OFS, 32'h2, 32'h2);
    check(32'(irq_out), 32'h1, "error irq");
    wr(CNLP_ESR_OFS, 32'h2);
    @(negedge ref_clk_in);
    check(32'(irq_out), 32'h0, "error cleared");
    $display("interrupt test done");
    end_sim();
  end
endmodule : test_cnlp_ctrl
